//--- logic/ums_pkg.sv
// How it works
// - reading modem status clears four change bits
// - bit 0 flags clear-to-send change
// - clear-to-send irq only without auto flow
// - bit 1 flags data-set-ready change, irq
// - bit 2 flags ring low-to-high only
// - bit 3 flags carrier detect change, irq
// - bit 4 inverted cts, loop uses rts
// - bit 5 inverted dsr, loop uses dtr
// - bit 6 inverted ri, loop uses user_output_one
// - bit 7 inverted dcd, loop uses user_output_two
// - divisor 1..65535 yields 16x enable
// - divisor held in two 8-bit latches
// - writing either latch reloads baud counter
// - shifter assembles chars into 16-entry fifo
// - receiver timed by 16x receive clock
// - char mode data-ready irq, read clears
// - fifo mode irq from trigger level setting
// - loopback disconnects inputs, feeds controls back
// - control bit 5 enables auto flow
package ums_pkg;
    localparam logic [2:0] OFF_DATA = 3'h0;
    localparam logic [2:0] OFF_IEN = 3'h1;
    localparam logic [2:0] OFF_FCTL = 3'h2;
    localparam logic [2:0] OFF_LCTL = 3'h3;
    localparam logic [2:0] OFF_MCTL = 3'h4;
    localparam logic [2:0] OFF_LSTAT = 3'h5;
    localparam logic [2:0] OFF_MSTAT = 3'h6;
    localparam int LCR_DIVISOR_ACCESS_BIT = 7;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_USER_OUTPUT_ONE = 2;
    localparam int MCR_USER_OUTPUT_TWO = 3;
    localparam int MCR_LOOP = 4;
    localparam int MCR_AFE = 5;
    localparam int IER_RDA = 0;
    localparam int IER_MS = 3;
    localparam int FCR_EN = 0;
    localparam int FCR_TRIG = 6;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_DIV = 16'h0000;
    localparam int FIFO_DEPTH = 16;
    localparam int OVS = 16;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [2:0] DATA_LAST = 3'h7;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } ums_rx_state_type;
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } ums_modem_type;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ums_bus_type;
endpackage : ums_pkg

//--- logic/ums_top.sv
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module ums_top (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire ums_pkg::ums_bus_type BUS,
    output logic [7:0] RDATA,
    input wire ums_pkg::ums_modem_type MODEM_N,
    input wire logic SERIAL_INPUT,
    input wire logic RCLK16,
    output logic BAUD16_EN,
    output logic DTR_N,
    output logic RTS_N,
    output logic USER_OUTPUT_ONE_N,
    output logic USER_OUTPUT_TWO_N,
    output logic MODEM_IRQ,
    output logic RX_IRQ
);
    import ums_pkg::*;

    function automatic logic [3:0] fifo_count(input logic [4:0] c);
        fifo_count = c[3:0];
    endfunction : fifo_count

    logic [7:0] ier_q, lcr_q, mcr_q, fcr_q;
    logic [7:0] dll_q, dlm_q;
    logic [15:0] bcnt_q;
    logic baud_q;
    logic rd_msr, rd_rbr, wr_dll, wr_dlm;
    logic divisor_access_bit;

    assign divisor_access_bit = lcr_q[LCR_DIVISOR_ACCESS_BIT];
    assign rd_msr = CE && BUS.rd && BUS.addr == OFF_MSTAT;
    assign rd_rbr = CE && BUS.rd && BUS.addr == OFF_DATA && !divisor_access_bit;
    assign wr_dll = CE && BUS.wr && BUS.addr == OFF_DATA && divisor_access_bit;
    assign wr_dlm = CE && BUS.wr && BUS.addr == OFF_IEN && divisor_access_bit;

    // control registers
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ier_q <= RST_BYTE;
            lcr_q <= RST_BYTE;
            mcr_q <= RST_BYTE;
            fcr_q <= RST_BYTE;
        end else if (CE && BUS.wr) begin
            unique case (BUS.addr)
                OFF_IEN: if (!divisor_access_bit) ier_q <= BUS.wdata;
                OFF_FCTL: fcr_q <= BUS.wdata;
                OFF_LCTL: lcr_q <= BUS.wdata;
                OFF_MCTL: mcr_q <= BUS.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            dll_q <= RST_DIV[7:0];
            dlm_q <= RST_DIV[15:8];
        end else begin
            if (wr_dll) dll_q <= BUS.wdata;
            if (wr_dlm) dlm_q <= BUS.wdata;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            bcnt_q <= RST_DIV;
            baud_q <= 1'b0;
        end else if (CE) begin
            baud_q <= 1'b0;
            if (wr_dll) begin
                bcnt_q <= {dlm_q, BUS.wdata};
            end else if (wr_dlm) begin
                bcnt_q <= {BUS.wdata, dll_q};
            end else if ({dlm_q, dll_q} != RST_DIV) begin
                if (bcnt_q <= 16'h0001) begin
                    bcnt_q <= {dlm_q, dll_q};
                    baud_q <= 1'b1;
                end else begin
                    bcnt_q <= bcnt_q - 16'h0001;
                end
            end
        end
    end
    assign BAUD16_EN = baud_q;

    // modem input synchronisers
    ums_modem_type m1_q, m2_q, prev_q;
    logic prev_ok_q;
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            m1_q <= '1;
            m2_q <= '1;
        end else if (CE) begin
            m1_q <= MODEM_N;
            m2_q <= m1_q;
        end
    end

    ums_modem_type live;
    always_comb begin
        if (mcr_q[MCR_LOOP]) begin
            live.cts = mcr_q[MCR_RTS];
            live.dsr = mcr_q[MCR_DTR];
            live.ri = mcr_q[MCR_USER_OUTPUT_ONE];
            live.dcd = mcr_q[MCR_USER_OUTPUT_TWO];
        end else begin
            live = ~m2_q;
        end
    end

    logic [3:0] delta_q;
    logic [3:0] ev;
    always_comb begin
        // cts change, masked by auto flow
        ev[0] = prev_ok_q && (live.cts != prev_q.cts) && !mcr_q[MCR_AFE];
        ev[1] = prev_ok_q && (live.dsr != prev_q.dsr);
        // ring trailing edge: pin low to high, status high to low
        ev[2] = prev_ok_q && prev_q.ri && !live.ri;
        ev[3] = prev_ok_q && (live.dcd != prev_q.dcd);
    end

    // read clears, a new event wins
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            delta_q <= 4'h0;
            prev_q <= '0;
            prev_ok_q <= 1'b0;
        end else if (CE) begin
            prev_q <= live;
            prev_ok_q <= 1'b1;
            delta_q <= (rd_msr ? 4'h0 : delta_q) | ev;
            if (mcr_q[MCR_AFE]) delta_q[0] <= 1'b0;
        end
    end

    // receive clock domain
    logic rc1_q, rc2_q, rc3_q, sin1_q, sin2_q, rx_bit;
    logic tick;
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rc1_q <= 1'b0;
            rc2_q <= 1'b0;
            rc3_q <= 1'b0;
            sin1_q <= 1'b1;
            sin2_q <= 1'b1;
        end else if (CE) begin
            rc1_q <= RCLK16;
            rc2_q <= rc1_q;
            rc3_q <= rc2_q;
            sin1_q <= SERIAL_INPUT;
            sin2_q <= sin1_q;
        end
    end
    // sample on rising edge of the 16x receive clock
    assign tick = CE && rc2_q && !rc3_q;
    assign rx_bit = mcr_q[MCR_LOOP] ? 1'b1 : sin2_q;

    ums_rx_state_type st_q;
    logic [3:0] ph_q;
    logic [2:0] bit_q;
    logic [7:0] shf_q;
    logic push;
    assign push = tick && st_q == RX_STOP && ph_q == OVS_LAST && rx_bit;

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            st_q <= RX_IDLE;
            ph_q <= 4'h0;
            bit_q <= 3'h0;
            shf_q <= RST_BYTE;
        end else if (tick) begin
            ph_q <= ph_q + 4'h1;
            unique case (st_q)
                RX_IDLE: begin
                    ph_q <= 4'h0;
                    if (!rx_bit) st_q <= RX_START;
                end
                RX_START: begin
                    if (ph_q == OVS_MID) begin
                        ph_q <= 4'h0;
                        st_q <= rx_bit ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (ph_q == OVS_LAST) begin
                        shf_q <= {rx_bit, shf_q[7:1]};
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == DATA_LAST) st_q <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (ph_q == OVS_LAST) st_q <= RX_IDLE;
                end
            endcase
        end
    end

    logic [7:0] mem_q [FIFO_DEPTH];
    logic [3:0] wp_q, rp_q;
    logic [4:0] cnt_q;
    logic fifo_mode, do_push, do_pop;
    assign fifo_mode = fcr_q[FCR_EN];
    assign do_pop = rd_rbr && cnt_q != 5'h00;
    assign do_push = push && (cnt_q != 5'h10 || do_pop);
    always_ff @(posedge MCLK) begin
        if (do_push) mem_q[wp_q] <= shf_q;
    end
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            wp_q <= 4'h0;
            rp_q <= 4'h0;
            cnt_q <= 5'h00;
        end else if (CE) begin
            if (do_push) wp_q <= wp_q + 4'h1;
            if (do_pop) rp_q <= rp_q + 4'h1;
            cnt_q <= cnt_q + {4'h0, do_push} - {4'h0, do_pop};
        end
    end

    logic [4:0] trig;
    always_comb begin
        unique case (fcr_q[FCR_TRIG +: 2])
            2'b00: trig = 5'h01;
            2'b01: trig = 5'h04;
            2'b10: trig = 5'h08;
            default: trig = 5'h0E;
        endcase
    end

    logic rx_irq_q, ms_irq_q;
    logic [7:0] rdata_q;
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rx_irq_q <= 1'b0;
            ms_irq_q <= 1'b0;
        end else if (CE) begin
            ms_irq_q <= ier_q[IER_MS] && delta_q != 4'h0;
            if (fifo_mode)
                rx_irq_q <= ier_q[IER_RDA] && cnt_q >= trig;
            else
                rx_irq_q <= ier_q[IER_RDA] && cnt_q != 5'h00;
        end
    end
    assign RX_IRQ = rx_irq_q;
    assign MODEM_IRQ = ms_irq_q;

    // read data, one cycle later
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rdata_q <= RST_BYTE;
        end else if (CE) begin
            rdata_q <= RST_BYTE;
            if (BUS.rd) begin
                unique case (BUS.addr)
                    OFF_DATA: rdata_q <= divisor_access_bit ? dll_q : mem_q[rp_q];
                    OFF_IEN: rdata_q <= divisor_access_bit ? dlm_q : ier_q;
                    OFF_LCTL: rdata_q <= lcr_q;
                    OFF_MCTL: rdata_q <= mcr_q;
                    OFF_LSTAT: rdata_q <= {7'h00, cnt_q != 5'h00};
                    OFF_MSTAT: rdata_q <= {live.dcd, live.ri, live.dsr,
                        live.cts, delta_q};
                    default: rdata_q <= RST_BYTE;
                endcase
            end
        end
    end
    assign RDATA = rdata_q;

    // modem outputs: set bit drives low, forced high in loopback
    logic [3:0] mout_q;
    always_ff @(posedge MCLK) begin
        if (SYS_RST) mout_q <= 4'hF;
        else if (CE) mout_q <= mcr_q[MCR_LOOP] ? 4'hF : ~mcr_q[3:0];
    end
    assign DTR_N = mout_q[0];
    assign RTS_N = mout_q[1];
    assign USER_OUTPUT_ONE_N = mout_q[2];
    assign USER_OUTPUT_TWO_N = mout_q[3];

    logic unused;
    assign unused = ^{fifo_count(cnt_q), BUS.wdata[0]};

    property p_msr_clear;
        @(posedge MCLK) disable iff (SYS_RST)
        rd_msr && ev == 4'h0 |=> delta_q == 4'h0;
    endproperty
    a_msr_clear: assert property (p_msr_clear)
        else $error("change bits kept");
    property p_afe;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && mcr_q[MCR_AFE] |=> !delta_q[0];
    endproperty
    a_afe: assert property (p_afe)
        else $error("cts change under auto flow");
    property p_loop;
        @(posedge MCLK) disable iff (SYS_RST)
        mcr_q[MCR_LOOP] |-> live.cts == mcr_q[MCR_RTS]
            && live.ri == mcr_q[MCR_USER_OUTPUT_ONE];
    endproperty
    a_loop: assert property (p_loop)
        else $error("loopback source wrong");
    property p_reload;
        @(posedge MCLK) disable iff (SYS_RST)
        wr_dll |=> bcnt_q == {dlm_q, dll_q};
    endproperty
    a_reload: assert property (p_reload)
        else $error("counter not reloaded");
    property p_char_irq;
        @(posedge MCLK) disable iff (SYS_RST)
        CE && !fifo_mode && ier_q[IER_RDA] && cnt_q != 5'h00 |=> rx_irq_q;
    endproperty
    a_char_irq: assert property (p_char_irq)
        else $error("no data irq");
    property p_fifo_cap;
        @(posedge MCLK) disable iff (SYS_RST)
        cnt_q <= 5'h10;
    endproperty
    a_fifo_cap: assert property (p_fifo_cap)
        else $error("fifo overfilled");
    // ring flag only rises after status ri fell, i.e. pin went high
    property p_ring;
        @(posedge MCLK) disable iff (SYS_RST)
        $rose(delta_q[2]) |-> $past(prev_q.ri) && !$past(live.ri);
    endproperty
    a_ring: assert property (p_ring)
        else $error("ring edge wrong");
    property p_baud;
        @(posedge MCLK) disable iff (SYS_RST)
        baud_q |-> !$past(baud_q) || {dlm_q, dll_q} == 16'h0001;
    endproperty
    a_baud: assert property (p_baud)
        else $error("baud pulse too close");
    c_push: cover property (@(posedge MCLK) do_push);
    c_msr: cover property (@(posedge MCLK) rd_msr && delta_q != 4'h0);
    c_baud: cover property (@(posedge MCLK) baud_q);
    c_ring: cover property (@(posedge MCLK) ev[2]);
    c_loop: cover property (@(posedge MCLK) mcr_q[MCR_LOOP] && rd_msr);
endmodule : ums_top
`default_nettype wire

//--- tb/ums_modem_model.sv
`timescale 1ns/1ns
`default_nettype none
module ums_modem_model
    import ums_pkg::*;
(
    input wire logic MCLK,
    output ums_pkg::ums_modem_type MODEM_N,
    output logic SERIAL_INPUT,
    output logic RCLK16
);
    logic [1:0] div_q = 2'h0;
    initial begin
        MODEM_N = 4'hF;
        SERIAL_INPUT = 1'b1;
    end
    always @(posedge MCLK) begin
        div_q <= div_q + 2'h1;
    end
    assign RCLK16 = div_q[1];
    task automatic set_lines(input ums_modem_type v);
        @(posedge MCLK);
        MODEM_N <= v;
    endtask : set_lines
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge MCLK);
            SERIAL_INPUT <= f[i];
            repeat (63) @(posedge MCLK);
        end
    endtask : send_byte
endmodule : ums_modem_model
`default_nettype wire

//--- tb/ums_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ums_tb_top;
    import ums_pkg::*;
    logic MCLK;
    logic SYS_RST;
    logic CE;
    ums_bus_type BUS;
    logic [7:0] RDATA;
    ums_modem_type MODEM_N;
    logic SERIAL_INPUT, RCLK16, BAUD16_EN, DTR_N, RTS_N, USER_OUTPUT_ONE_N, USER_OUTPUT_TWO_N;
    logic MODEM_IRQ, RX_IRQ;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    logic [7:0] d;
    logic [15:0] g;
    logic [7:0] lb [4] = '{8'h20, 8'h10, 8'h40, 8'h80};
    logic [15:0] dv [3] = '{16'h0001, 16'h0003, 16'h012C};

    ums_top i_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .CE(CE), .BUS(BUS),
        .RDATA(RDATA), .MODEM_N(MODEM_N), .SERIAL_INPUT(SERIAL_INPUT),
        .RCLK16(RCLK16), .BAUD16_EN(BAUD16_EN), .DTR_N(DTR_N),
        .RTS_N(RTS_N), .USER_OUTPUT_ONE_N(USER_OUTPUT_ONE_N), .USER_OUTPUT_TWO_N(USER_OUTPUT_TWO_N),
        .MODEM_IRQ(MODEM_IRQ), .RX_IRQ(RX_IRQ));
    ums_modem_model i_modem (.MCLK(MCLK), .MODEM_N(MODEM_N),
        .SERIAL_INPUT(SERIAL_INPUT), .RCLK16(RCLK16));

    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge MCLK);
        BUS <= {a, v, 2'b10};
        @(posedge MCLK);
        BUS <= {a, v, 2'b00};
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge MCLK);
        BUS <= {a, 8'h00, 2'b01};
        @(posedge MCLK);
        BUS <= {a, 8'h00, 2'b00};
        #1;
        v = RDATA;
    endtask : rd
    task automatic modem_line_status(input string what, input logic [7:0] exp);
        rd(OFF_MSTAT, d);
        chk(what, exp, d);
    endtask : modem_line_status
    // synchroniser plus status register latency
    task automatic settle;
        repeat (6) @(posedge MCLK);
        #1;
    endtask : settle
    task automatic wait_rx;
        n = 0;
        while (RX_IRQ !== 1'b1 && n < 200) begin
            @(posedge MCLK);
            #1;
            n++;
        end
    endtask : wait_rx
    // the latch write reloads the counter: first pulse a full divisor later
    task automatic gap(output int first, output logic [15:0] per);
        first = 0;
        do begin @(posedge MCLK); #1; first++; end
        while (BAUD16_EN !== 1'b1 && first < 70000);
        repeat (2) begin
            per = 16'h0000;
            do begin @(posedge MCLK); #1; per++; end
            while (BAUD16_EN !== 1'b1 && per < 16'hFFFF);
        end
    endtask : gap
    task automatic done(input string t);
        $display("test %s done, mismatches %0d", t, fails);
    endtask : done
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("MISMATCH run length expected end seen hang");
            summarize();
        end
    end

    initial begin
        SYS_RST = 1'b1;
        CE = 1'b1;
        BUS = '0;
        repeat (10) @(posedge MCLK);
        SYS_RST <= 1'b0;
        settle;
        modem_line_status("msr reset", 8'h00);
        wr(OFF_IEN, 8'h09);
        i_modem.set_lines(4'b1110);
        settle;
        chk("modem irq cts", 1'b1, MODEM_IRQ);
        modem_line_status("msr cts", 8'h11);
        modem_line_status("msr cleared", 8'h10);
        chk("modem irq cleared", 1'b0, MODEM_IRQ);
        i_modem.set_lines(4'b0100);
        settle;
        chk("modem irq dsr dcd", 1'b1, MODEM_IRQ);
        modem_line_status("msr dsr dcd", 8'hBA);
        i_modem.set_lines(4'b0000);
        settle;
        chk("modem irq ring on", 1'b0, MODEM_IRQ);
        modem_line_status("msr ring on", 8'hF0);
        i_modem.set_lines(4'b0100);
        settle;
        chk("modem irq ring off", 1'b1, MODEM_IRQ);
        modem_line_status("msr ring off", 8'hB4);
        wr(OFF_MCTL, 8'h20);
        i_modem.set_lines(4'b0101);
        settle;
        chk("modem irq auto flow", 1'b0, MODEM_IRQ);
        modem_line_status("msr auto flow", 8'hA0);
        done("modem status");
        // pins move too, loopback must ignore them
        for (int i = 0; i < 4; i++) begin
            wr(OFF_MCTL, 8'h10 | (8'h01 << i));
            i_modem.set_lines(4'(i));
            settle;
            rd(OFF_MSTAT, d);
            chk("loop status", lb[i], d & 8'hF0);
            chk("loop outs", 4'hF, {USER_OUTPUT_TWO_N, USER_OUTPUT_ONE_N, RTS_N, DTR_N});
        end
        wr(OFF_MCTL, 8'h00);
        i_modem.set_lines(4'hF);
        settle;
        rd(OFF_MSTAT, d);
        // a frozen block ignores the bus
        @(posedge MCLK);
        CE <= 1'b0;
        wr(OFF_MCTL, 8'h05);
        CE <= 1'b1;
        repeat (2) @(posedge MCLK);
        #1;
        chk("outs frozen", 4'hF, {USER_OUTPUT_TWO_N, USER_OUTPUT_ONE_N, RTS_N, DTR_N});
        wr(OFF_MCTL, 8'h05);
        repeat (2) @(posedge MCLK);
        #1;
        chk("modem outs", 4'hA, {USER_OUTPUT_TWO_N, USER_OUTPUT_ONE_N, RTS_N, DTR_N});
        done("loopback");
        wr(OFF_LCTL, 8'h80);
        // divisor = ref / (baud * 16), both latches set first
        for (int i = 0; i < 3; i++) begin
            wr(OFF_IEN, dv[i][15:8]);
            wr(OFF_DATA, dv[i][7:0]);
            gap(n, g);
            chk("baud first", dv[i], 16'(n));
            chk("baud period", dv[i], g);
        end
        wr(OFF_LCTL, 8'h00);
        done("baud");
        wr(OFF_IEN, 8'h01);
        i_modem.send_byte(8'hA5);
        wait_rx;
        chk("rx irq", 1'b1, RX_IRQ);
        rd(OFF_DATA, d);
        chk("rx data", 8'hA5, d);
        @(posedge MCLK);
        #1;
        chk("rx irq cleared", 1'b0, RX_IRQ);
        wr(OFF_FCTL, 8'h41);
        for (int i = 0; i < 4; i++) begin
            i_modem.send_byte(8'h30 + 8'(i));
            if (i == 2) chk("rx irq below", 1'b0, RX_IRQ);
        end
        wait_rx;
        chk("rx irq trigger", 1'b1, RX_IRQ);
        for (int i = 0; i < 4; i++) begin
            rd(OFF_DATA, d);
            chk("fifo data", 8'h30 + 8'(i), d);
        end
        done("receive");
        summarize();
    end
endmodule : ums_tb_top
`default_nettype wire
